//--- core/exd_datapath.sv
// exd_datapath: exchange, digit exchange and xor datapath slice
// assumes: decoder issues one op per i_start while o_busy is low;
// memory read data returns one cycle after o_mem_rd; port latch
// readback is supplied by the port block on i_mem_rdata for sfr reads.
`timescale 1ns/1ps
module exd_datapath
  import exd_pkg::*;
(
  // clock and reset
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst,
  // decoder request
  input  wire logic                   i_start,
  input  wire exd_op_type             i_op,
  input  wire logic [EXD_AW-1:0]      i_addr,
  input  wire logic [EXD_DW-1:0]      i_imm,
  input  wire logic                   i_ptr_sel,
  input  wire logic [1:0]             i_bank,
  // memory / sfr access
  output logic      [EXD_AW-1:0]      o_mem_addr,
  output logic                        o_mem_rd,
  output logic                        o_mem_latch_rd,
  output logic                        o_mem_wr,
  output logic      [EXD_DW-1:0]      o_mem_wdata,
  input  wire logic [EXD_DW-1:0]      i_mem_rdata,
  // accumulator and status
  output logic      [EXD_DW-1:0]      o_acc,
  output logic                        o_flags_we,
  output logic                        o_busy,
  output logic                        o_done
);
  exd_state_type          state_q, state_d;
  exd_op_type             op_q, op_d;
  logic [EXD_AW-1:0]      addr_q, addr_d;
  logic [EXD_DW-1:0]      imm_q, imm_d;
  logic [EXD_DW-1:0]      acc_q, acc_d;
  logic [EXD_DW-1:0]      opnd_q, opnd_d;
  logic [EXD_DW-1:0]      wdata_q, wdata_d;
  logic                   rd_q, rd_d;
  logic                   lrd_q, lrd_d;
  logic                   wr_q, wr_d;
  logic                   done_q, done_d;
  logic                   ptr_sel_q, ptr_sel_d;
  logic [1:0]             bank_q, bank_d;
  logic [EXD_DW-1:0]      acc_new, mem_new;
  logic                   acc_we, mem_we;
  logic                   need_mem, is_ind, dir_dest;
  logic                   is_reg;
  logic                   busy_q, busy_d;
  logic                   flags_we_q;

  exd_alu u_alu (
    .i_op      (op_q),
    .i_acc     (acc_q),
    .i_opnd    (opnd_q),
    .i_imm     (imm_q),
    .o_acc_new (acc_new),
    .o_mem_new (mem_new),
    .o_acc_we  (acc_we),
    .o_mem_we  (mem_we)
  );

  always_comb
  begin
    // decoded from the request so the first access issues at once
    is_ind   = (i_op == EXD_OP_XCH_IND) || (i_op == EXD_OP_DIGIT_EXCHANGE_OP_IND) ||
               (i_op == EXD_OP_XOR_A_IND);
    need_mem = (i_op != EXD_OP_XOR_A_IMM) && (i_op != EXD_OP_NONE);
    dir_dest = (i_op == EXD_OP_XOR_DIR_A) ||
               (i_op == EXD_OP_XOR_DIR_IMM);
    is_reg   = (i_op == EXD_OP_XCH_REG) || (i_op == EXD_OP_XOR_A_REG);
  end

  always_comb
  begin
    state_d   = state_q;
    op_d      = op_q;
    addr_d    = addr_q;
    imm_d     = imm_q;
    acc_d     = acc_q;
    opnd_d    = opnd_q;
    wdata_d   = wdata_q;
    rd_d      = 1'b0;
    lrd_d     = 1'b0;
    wr_d      = 1'b0;
    done_d    = 1'b0;
    busy_d    = busy_q;
    ptr_sel_d = ptr_sel_q;
    bank_d    = bank_q;
    case (state_q)
      EXD_ST_IDLE:
      begin
        if (i_start && i_op != EXD_OP_NONE)
        begin
          op_d      = i_op;
          imm_d     = i_imm;
          ptr_sel_d = i_ptr_sel;
          bank_d    = i_bank;
          busy_d    = 1'b1;
          if (is_reg)
            // register forms: i_addr holds the register number
            addr_d = {3'h0, i_bank, i_addr[2:0]};
          else
            addr_d = i_addr;
          if (is_ind)
          begin
            // fetch pointer register 0 or 1 of the active bank first
            addr_d  = {3'h0, i_bank, 2'h0, i_ptr_sel};
            rd_d    = 1'b1;
            state_d = EXD_ST_PTR;
          end
          else if (need_mem)
          begin
            // read-modify-write of a port uses the output latch
            lrd_d   = dir_dest && (i_addr >= EXD_SFR_BASE);
            rd_d    = !lrd_d;
            state_d = EXD_ST_READ;
          end
          else
            state_d = EXD_ST_WRITE;
        end
      end
      EXD_ST_PTR:
      begin
        // read data trails the strobe by one cycle, so skip that cycle
        if (!rd_q)
        begin
          addr_d  = i_mem_rdata;
          rd_d    = 1'b1;
          state_d = EXD_ST_READ;
        end
      end
      EXD_ST_READ:
      begin
        if (!rd_q && !lrd_q)
        begin
          opnd_d  = i_mem_rdata;
          state_d = EXD_ST_WRITE;
        end
      end
      EXD_ST_WRITE:
      begin
        // one write slot serves every form; no flag is ever touched
        if (acc_we)
          acc_d = acc_new;
        if (mem_we)
        begin
          wdata_d = mem_new;
          wr_d    = 1'b1;
        end
        done_d  = 1'b1;
        busy_d  = 1'b0;
        state_d = EXD_ST_IDLE;
      end
      default:
      begin
        state_d = EXD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      state_q   <= EXD_ST_IDLE;
      op_q      <= EXD_OP_NONE;
      addr_q    <= EXD_RST_BYTE;
      imm_q     <= EXD_RST_BYTE;
      acc_q     <= EXD_ACC_RST;
      opnd_q    <= EXD_RST_BYTE;
      wdata_q   <= EXD_RST_BYTE;
      rd_q      <= 1'b0;
      lrd_q     <= 1'b0;
      wr_q      <= 1'b0;
      done_q    <= 1'b0;
      ptr_sel_q <= 1'b0;
      bank_q    <= 2'h0;
      busy_q    <= 1'b0;
      flags_we_q <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      op_q      <= op_d;
      addr_q    <= addr_d;
      imm_q     <= imm_d;
      acc_q     <= acc_d;
      opnd_q    <= opnd_d;
      wdata_q   <= wdata_d;
      rd_q      <= rd_d;
      lrd_q     <= lrd_d;
      wr_q      <= wr_d;
      done_q    <= done_d;
      ptr_sel_q <= ptr_sel_d;
      bank_q    <= bank_d;
      busy_q    <= busy_d;
      flags_we_q <= 1'b0;
    end
  end

  // every output comes straight from its register
  assign o_mem_addr     = addr_q;
  assign o_mem_rd       = rd_q;
  assign o_mem_latch_rd = lrd_q;
  assign o_mem_wr       = wr_q;
  assign o_mem_wdata    = wdata_q;
  assign o_acc          = acc_q;
  assign o_flags_we     = flags_we_q;
  assign o_busy         = busy_q;
  assign o_done         = done_q;

  // flag strobe never raised; write slot results, port latch read and pointer fetch checked one cycle after the request or write slot
  property p_flags_still;
    @(posedge i_sys_clk) disable iff (i_rst) !o_flags_we;
  endproperty
  a_flags_still: assert property (p_flags_still)
    else $error("status flag write strobe seen");
  property p_byte_swap;
    @(posedge i_sys_clk) disable iff (i_rst)
      (state_q == EXD_ST_WRITE && op_q inside {EXD_OP_XCH_REG,
       EXD_OP_XCH_DIR, EXD_OP_XCH_IND})
      |=> wr_q && acc_q == $past(opnd_q) && wdata_q == $past(acc_q);
  endproperty
  a_byte_swap: assert property (p_byte_swap)
    else $error("byte exchange result wrong");
  property p_digit_low;
    @(posedge i_sys_clk) disable iff (i_rst)
      (state_q == EXD_ST_WRITE && op_q == EXD_OP_DIGIT_EXCHANGE_OP_IND) |=> wr_q &&
      acc_q[EXD_NIB_HI:EXD_NIB_LO] == $past(opnd_q[EXD_NIB_HI:EXD_NIB_LO]) &&
      wdata_q[EXD_NIB_HI:EXD_NIB_LO] == $past(acc_q[EXD_NIB_HI:EXD_NIB_LO]);
  endproperty
  a_digit_low: assert property (p_digit_low)
    else $error("digit exchange low nibbles wrong");
  property p_digit_high;
    @(posedge i_sys_clk) disable iff (i_rst)
      (state_q == EXD_ST_WRITE && op_q == EXD_OP_DIGIT_EXCHANGE_OP_IND) |=>
      acc_q[EXD_DW-1:EXD_NIB_W] == $past(acc_q[EXD_DW-1:EXD_NIB_W]) &&
      wdata_q[EXD_DW-1:EXD_NIB_W] == $past(opnd_q[EXD_DW-1:EXD_NIB_W]);
  endproperty
  a_digit_high: assert property (p_digit_high)
    else $error("digit exchange high nibbles changed");
  property p_xor_acc;
    @(posedge i_sys_clk) disable iff (i_rst)
      (state_q == EXD_ST_WRITE && op_q inside {EXD_OP_XOR_A_REG,
       EXD_OP_XOR_A_DIR, EXD_OP_XOR_A_IND, EXD_OP_XOR_A_IMM}) |=>
      !wr_q && acc_q == ($past(acc_q) ^ (($past(op_q) == EXD_OP_XOR_A_IMM)
      ? $past(imm_q) : $past(opnd_q)));
  endproperty
  a_xor_acc: assert property (p_xor_acc)
    else $error("xor into accumulator wrong");
  property p_xor_dir;
    @(posedge i_sys_clk) disable iff (i_rst)
      (state_q == EXD_ST_WRITE && op_q inside {EXD_OP_XOR_DIR_A,
       EXD_OP_XOR_DIR_IMM}) |=> wr_q && acc_q == $past(acc_q) &&
      wdata_q == ($past(opnd_q) ^ (($past(op_q) == EXD_OP_XOR_DIR_A)
      ? $past(acc_q) : $past(imm_q)));
  endproperty
  a_xor_dir: assert property (p_xor_dir)
    else $error("xor into direct byte wrong");
  property p_port_latch;
    @(posedge i_sys_clk) disable iff (i_rst)
      (state_q == EXD_ST_IDLE && i_start &&
       i_op inside {EXD_OP_XOR_DIR_A, EXD_OP_XOR_DIR_IMM} &&
       i_addr >= EXD_SFR_BASE) |=> lrd_q && !rd_q;
  endproperty
  a_port_latch: assert property (p_port_latch)
    else $error("port update did not read the output latch");
  property p_ptr_fetch;
    @(posedge i_sys_clk) disable iff (i_rst)
      (state_q == EXD_ST_IDLE && i_start &&
       i_op inside {EXD_OP_XCH_IND, EXD_OP_DIGIT_EXCHANGE_OP_IND, EXD_OP_XOR_A_IND})
      |=> rd_q && addr_q == {3'h0, $past(i_bank), 2'h0, $past(i_ptr_sel)};
  endproperty
  a_ptr_fetch: assert property (p_ptr_fetch)
    else $error("pointer register fetch address wrong");
  c_digit_swap: cover property (@(posedge i_sys_clk)
    state_q == EXD_ST_WRITE && op_q == EXD_OP_DIGIT_EXCHANGE_OP_IND);
  c_port_rmw: cover property (@(posedge i_sys_clk) lrd_q);
  c_ptr_fetch: cover property (@(posedge i_sys_clk)
    state_q == EXD_ST_PTR && !rd_q);
endmodule : exd_datapath

//--- core/exd_pkg.sv
// exd_pkg: constants and types for the exchange/xor datapath slice
// assumes: 8-bit core, 256-byte internal space, four register banks
package exd_pkg;
  localparam int          EXD_DW        = 8;
  localparam int          EXD_AW        = 8;
  localparam int          EXD_NIB_LO    = 0;
  localparam int          EXD_NIB_HI    = 3;
  localparam int          EXD_NIB_W     = 4;
  localparam logic [7:0]  EXD_ACC_RST   = 8'h00;
  localparam logic [7:0]  EXD_RST_BYTE  = 8'h00;
  localparam logic [1:0]  EXD_BANK_SH   = 2'h3;
  // special function area starts here; port latches live above
  localparam logic [7:0]  EXD_SFR_BASE  = 8'h80;

  typedef enum logic [3:0] {
    EXD_OP_NONE,
    EXD_OP_XCH_REG,
    EXD_OP_XCH_DIR,
    EXD_OP_XCH_IND,
    EXD_OP_DIGIT_EXCHANGE_OP_IND,
    EXD_OP_XOR_A_REG,
    EXD_OP_XOR_A_DIR,
    EXD_OP_XOR_A_IND,
    EXD_OP_XOR_A_IMM,
    EXD_OP_XOR_DIR_A,
    EXD_OP_XOR_DIR_IMM
  } exd_op_type;

  typedef enum {
    EXD_ST_IDLE,
    EXD_ST_PTR,
    EXD_ST_READ,
    EXD_ST_WRITE
  } exd_state_type;
endpackage : exd_pkg

//--- core/exd_alu.sv
// exd_alu: byte combine for exchange, digit exchange and xor
// assumes: pure combinational, operands already fetched
`timescale 1ns/1ps
module exd_alu
  import exd_pkg::*;
(
  // operation and operands
  input  wire exd_op_type             i_op,
  input  wire logic [EXD_DW-1:0]      i_acc,
  input  wire logic [EXD_DW-1:0]      i_opnd,
  input  wire logic [EXD_DW-1:0]      i_imm,
  // results
  output logic      [EXD_DW-1:0]      o_acc_new,
  output logic      [EXD_DW-1:0]      o_mem_new,
  output logic                        o_acc_we,
  output logic                        o_mem_we
);
  always_comb
  begin
    o_acc_new = i_acc;
    o_mem_new = i_opnd;
    o_acc_we  = 1'b0;
    o_mem_we  = 1'b0;
    case (i_op)
      EXD_OP_XCH_REG, EXD_OP_XCH_DIR, EXD_OP_XCH_IND:
      begin
        o_acc_new = i_opnd;
        o_mem_new = i_acc;
        o_acc_we  = 1'b1;
        o_mem_we  = 1'b1;
      end
      EXD_OP_DIGIT_EXCHANGE_OP_IND:
      begin
        // high nibbles kept on both sides
        o_acc_new = {i_acc[EXD_DW-1:EXD_NIB_W],
                     i_opnd[EXD_NIB_HI:EXD_NIB_LO]};
        o_mem_new = {i_opnd[EXD_DW-1:EXD_NIB_W],
                     i_acc[EXD_NIB_HI:EXD_NIB_LO]};
        o_acc_we  = 1'b1;
        o_mem_we  = 1'b1;
      end
      EXD_OP_XOR_A_REG, EXD_OP_XOR_A_DIR, EXD_OP_XOR_A_IND:
      begin
        o_acc_new = i_acc ^ i_opnd;
        o_acc_we  = 1'b1;
      end
      EXD_OP_XOR_A_IMM:
      begin
        o_acc_new = i_acc ^ i_imm;
        o_acc_we  = 1'b1;
      end
      EXD_OP_XOR_DIR_A:
      begin
        o_mem_new = i_opnd ^ i_acc;
        o_mem_we  = 1'b1;
      end
      EXD_OP_XOR_DIR_IMM:
      begin
        o_mem_new = i_opnd ^ i_imm;
        o_mem_we  = 1'b1;
      end
      default:
      begin
        o_acc_we = 1'b0;
      end
    endcase
  end
endmodule : exd_alu

//--- tb/exd_datapath_tb_top.sv
// exd_datapath_tb_top: self-checking bench for the exchange/xor slice
// assumes: one op per i_start while o_busy is low, o_done ends it,
// read data one cycle after o_mem_rd or o_mem_latch_rd
`timescale 1ns/1ps
module exd_datapath_tb_top
  import exd_pkg::*;
;
  logic             i_sys_clk = 1'b0;
  logic             i_rst = 1'b1;
  logic             i_start = 1'b0;
  exd_op_type       i_op = EXD_OP_NONE;
  logic [7:0]       i_addr = 8'h00;
  logic [7:0]       i_imm = 8'h00;
  logic             i_ptr_sel = 1'b0;
  logic [1:0]       i_bank = 2'h0;
  logic [7:0]       i_mem_rdata = 8'h00;
  logic [7:0]       o_mem_addr, o_mem_wdata, o_acc;
  logic             o_mem_rd, o_mem_latch_rd, o_mem_wr;
  logic             o_flags_we, o_busy, o_done;
  logic [7:0]       ram [256];
  logic [7:0]       ex [256];
  logic [7:0]       acc = EXD_ACC_RST;
  logic [31:0]      rng = 32'h5f92;
  logic             fl = 1'b0;
  logic             lt = 1'b0;
  int               err_total = 0;
  int               check_count = 0;
  int               cyc = 0;

  always #5 i_sys_clk = ~i_sys_clk;

  exd_datapath u_exd_datapath (
    .i_sys_clk      (i_sys_clk),
    .i_rst          (i_rst),
    .i_start        (i_start),
    .i_op           (i_op),
    .i_addr         (i_addr),
    .i_imm          (i_imm),
    .i_ptr_sel      (i_ptr_sel),
    .i_bank         (i_bank),
    .o_mem_addr     (o_mem_addr),
    .o_mem_rd       (o_mem_rd),
    .o_mem_latch_rd (o_mem_latch_rd),
    .o_mem_wr       (o_mem_wr),
    .o_mem_wdata    (o_mem_wdata),
    .i_mem_rdata    (i_mem_rdata),
    .o_acc          (o_acc),
    .o_flags_we     (o_flags_we),
    .o_busy         (o_busy),
    .o_done         (o_done)
  );

  // released data bus must not keep the last byte
  always @(posedge i_sys_clk)
  begin
    if (o_mem_rd || o_mem_latch_rd) i_mem_rdata <= ram[o_mem_addr];
    else i_mem_rdata <= ~i_mem_rdata;
    if (o_mem_wr) ram[o_mem_addr] <= o_mem_wdata;
    if (o_flags_we === 1'b1) fl <= 1'b1;
    if (o_mem_latch_rd === 1'b1) lt <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      complete_run();
    end
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run();
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task automatic run_op(input exd_op_type op);
    logic [7:0] a;
    logic [7:0] t;
    int         n;
    n = 0;
    while (o_busy !== 1'b0 && n < 50)
    begin
      @(posedge i_sys_clk);
      n++;
    end
    if (n == 50) err_total++;
    rng = nxt(rng);
    i_op <= op;
    i_addr <= rng[7:0];
    i_imm <= rng[15:8];
    i_ptr_sel <= rng[16];
    i_bank <= rng[18:17];
    i_start <= 1'b1;
    fl <= 1'b0;
    lt <= 1'b0;
    @(posedge i_sys_clk);
    i_start <= 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 50)
    begin
      @(posedge i_sys_clk);
      n++;
    end
    if (n == 50) err_total++;
    @(posedge i_sys_clk);
    a = rng[7:0];
    // register forms live in the active bank
    if (op inside {EXD_OP_XCH_REG, EXD_OP_XOR_A_REG})
      a = {3'h0, rng[18:17], rng[2:0]};
    if (op inside {EXD_OP_XCH_IND, EXD_OP_DIGIT_EXCHANGE_OP_IND, EXD_OP_XOR_A_IND})
      a = ex[{3'h0, rng[18:17], 2'h0, rng[16]}];
    t = ex[a];
    case (op)
      EXD_OP_XCH_REG, EXD_OP_XCH_DIR, EXD_OP_XCH_IND:
      begin
        ex[a] = acc;
        acc = t;
      end
      EXD_OP_DIGIT_EXCHANGE_OP_IND:
      begin
        ex[a] = {t[7:4], acc[3:0]};
        acc = {acc[7:4], t[3:0]};
      end
      EXD_OP_XOR_A_IMM: acc = acc ^ rng[15:8];
      EXD_OP_XOR_DIR_A: ex[a] = t ^ acc;
      EXD_OP_XOR_DIR_IMM: ex[a] = t ^ rng[15:8];
      default: acc = acc ^ t;
    endcase
    chk(o_acc, acc);
    chk(ram[a], ex[a]);
    chk({7'h0, fl}, 8'h00);
    if (op inside {EXD_OP_XOR_DIR_A, EXD_OP_XOR_DIR_IMM} && a >= EXD_SFR_BASE)
      chk({7'h0, lt}, 8'h01);
  endtask : run_op

  initial
  begin
    for (int i = 0; i < 256; i++)
    begin
      rng = nxt(rng);
      ram[i] = rng[7:0];
      ex[i] = rng[7:0];
    end
    repeat (4) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    chk(o_acc, EXD_ACC_RST);
    for (int i = 0; i < 60; i++)
      run_op(exd_op_type'(4'(1 + i % 10)));
    complete_run();
  end
endmodule : exd_datapath_tb_top
